// ---- logic/spe_map.vh ----
// Constants of the serial EEPROM command block: opcodes, status layout,
// array geometry and write-cycle timing. Included by the design files only.
`ifndef SPE_MAP_VH
`define SPE_MAP_VH

// System clock rate and the self-timed write cycle.
`define SPE_CLK_MHZ      10
`define SPE_TWC_US       5000
// Write time in clocks (5000 us at 10 MHz), sized to fit the 16-bit timer.
`define SPE_TWC_CYCLES   16'hC350
`define SPE_TW           16

// Array geometry: 4096 bytes, 32-byte pages.
`define SPE_AW           12
`define SPE_MEM_BYTES    4096
`define SPE_PW           5
`define SPE_PAGE_BYTES   32
`define SPE_ADDR_ONE     12'h001
`define SPE_PAGE_ONE     5'h01

// Opcode: upper nibble must be zero, bit 3 is don't care.
`define SPE_OP_HI        4'h0
`define SPE_OP_LATCH_SET 3'h6
`define SPE_OP_LATCH_CLR 3'h4
`define SPE_OP_STATE_RD  3'h5
`define SPE_OP_STATE_WR  3'h1
`define SPE_OP_ARR_RD    3'h3
`define SPE_OP_ARR_WR    3'h2

// Status byte field positions and values.
`define SPE_SR_ARM       7
`define SPE_SR_BPH       3
`define SPE_SR_BPL       2
`define SPE_SR_WEL       1
`define SPE_SR_BUSY      0
`define SPE_SR_BUSYVAL   8'hFF
`define SPE_NV_RESET     3'h0
`define SPE_IDLE_BYTE    8'hFF

`endif

// ---- logic/spe_sync.v ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
module spe_sync #(
  parameter W = 5
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_q;
  reg [W-1:0] stab_q;

  // Reset to all ones: chip select, pause and protect pins idle high.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= {W{1'b1}};
      stab_q <= {W{1'b1}};
    end else begin
      meta_q <= din;
      stab_q <= meta_q;
    end
  end

  assign dout = stab_q;
endmodule // spe_sync

// ---- logic/spe_fifo.v ----
// Small synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes a single clock; flush wins over a push in the same cycle.
`timescale 1ns/1ps
module spe_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter PW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] store_q [0:DEPTH-1];
  reg [PW-1:0]    wrPtr_q;
  reg [PW-1:0]    rdPtr_q;
  reg [PW:0]      count_q;
  wire            push;
  wire            pop;

  assign inReady  = (count_q != DEPTH[PW:0]);
  assign outValid = (count_q != {(PW+1){1'b0}});
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = store_q[rdPtr_q];

  always @(posedge clk) begin
    if (push && !flush) begin
      store_q[wrPtr_q] <= inData;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= {PW{1'b0}};
      rdPtr_q <= {PW{1'b0}};
      count_q <= {(PW+1){1'b0}};
    end else if (flush) begin
      wrPtr_q <= {PW{1'b0}};
      rdPtr_q <= {PW{1'b0}};
      count_q <= {(PW+1){1'b0}};
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_q <= count_q + {{PW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_q <= count_q - {{PW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // spe_fifo

// ---- logic/spe_eeprom.v ----
// Serial EEPROM command logic: SPI mode 0 slave, 4096-byte array in flops,
// page writes, status byte with block and pin protection, self-timed write.
// Assumes pins arrive asynchronously and SCK is far slower than clk.
// Notes on behaviour
// - bytes MSB first, command starts at select fall.
// - decode latch set, latch clear, status read.
// - decode status write, array read, array write.
// - latch cleared after reset.
// - latch clear disables programming regardless of pin.
// - status byte: arm, protect level, latch, busy.
// - bit 0 shows write cycle running.
// - bit 1 shows latch state.
// - bits 4 to 6 read zero when idle.
// - all status bits one while busy.
// - protect level selects refused upper range.
// - protect and arm bits written via timed cycle.
// - pin low plus arm refuses status writes.
// - array and status writes need latch set.
// - arm cannot clear while pin protection holds.
// - read sends opcode, address; device streams data.
// - read address increments and wraps to zero.
// - write sends opcode, address, data bytes.
// - write without latch ignored until next select.
// - programming starts at select rise after byte.
// - page write wraps in five low bits.
// - busy ignores all but status read; clears latch.
// - unknown opcode: ignore rest, output stays off.
// - deselected: ignore input, output off.
// - pause pin suspends sequence, ignores input.
`timescale 1ns/1ps
`include "spe_map.vh"
module spe_eeprom #(
  parameter [`SPE_TW-1:0] WRITE_CYCLES = `SPE_TWC_CYCLES
) (
  input  wire clk,
  input  wire rst,
  input  wire csPinN,
  input  wire sckPin,
  input  wire siPin,
  input  wire holdPinN,
  input  wire wpPinN,
  output wire soOut,
  output wire soOe,
  output wire busy
);
  localparam [2:0] ST_OPC   = 3'h0;
  localparam [2:0] ST_ADDR  = 3'h1;
  localparam [2:0] ST_RDATA = 3'h2;
  localparam [2:0] ST_WDATA = 3'h3;
  localparam [2:0] ST_SRWR  = 3'h4;
  localparam [2:0] ST_STAT  = 3'h5;
  localparam [2:0] ST_IGN   = 3'h6;

  reg  [7:0]           mem_q [0:`SPE_MEM_BYTES-1];
  reg  [7:0]           page_q [0:`SPE_PAGE_BYTES-1];
  reg  [2:0]           state_q;
  reg  [2:0]           bitCnt_q;
  reg  [7:0]           rx_q;
  reg  [7:0]           addrHi_q;
  reg                  addrByte_q;
  reg                  rdMode_q;
  reg  [`SPE_AW-1:0]   rdAddr_q;
  reg  [`SPE_AW-1:0]   wrAddr_q;
  reg  [31:0]          mask_q;
  reg                  byteEnd_q;
  reg  [2:0]           srPend_q;
  reg                  pendArr_q;
  reg                  pendSr_q;
  reg                  busy_q;
  reg  [`SPE_TW-1:0]   timer_q;
  reg                  wel_q;
  reg                  arm_q;
  reg  [1:0]           bp_q;
  reg  [7:0]           tx_q;
  reg                  so_q;
  reg                  soAct_q;
  reg                  sckPrev_q;
  reg                  csPrev_q;
  wire [4:0]           pinS;
  wire                 csS;
  wire                 sckS;
  wire                 siS;
  wire                 holdS;
  wire                 wpS;
  wire                 sckRise;
  wire                 sckFall;
  wire                 csRise;
  wire                 csFall;
  wire [7:0]           rxByte;
  wire                 byteDone;
  wire                 hwProt;
  wire                 timerDone;
  wire                 startArr;
  wire                 startSr;
  wire [7:0]           statusByte;
  wire                 txLoad;
  wire [7:0]           txByte;
  wire                 fifoInReady;
  wire                 fifoOutValid;
  wire [7:0]           fifoOutData;
  wire                 fillPush;
  wire [15:0]          fullAddr;
  integer              i;

  // Upper quarter, upper half or the whole array; the quarters are aligned
  // to pages, so checking the write address covers every byte of the page.
  function prot;
    input [1:0]         lvl;
    input [`SPE_AW-1:0] a;
    begin
      case (lvl)
        2'h0: prot = 1'b0;
        2'h1: prot = (a[`SPE_AW-1:`SPE_AW-2] == 2'h3);
        2'h2: prot = a[`SPE_AW-1];
        default: prot = 1'b1;
      endcase
    end
  endfunction

  spe_sync #(
    .W(5)
  ) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({csPinN, sckPin, siPin, holdPinN, wpPinN}),
    .dout (pinS)
  );

  assign csS   = pinS[4];
  assign sckS  = pinS[3];
  assign siS   = pinS[2];
  assign holdS = pinS[1];
  assign wpS   = pinS[0];

  assign sckRise  = sckS & ~sckPrev_q & ~csS & holdS;
  assign sckFall  = ~sckS & sckPrev_q & ~csS & holdS;
  assign csRise   = csS & ~csPrev_q;
  assign csFall   = ~csS & csPrev_q;
  assign rxByte   = {rx_q[6:0], siS};
  assign byteDone = sckRise & (bitCnt_q == 3'h7);
  assign hwProt   = ~wpS & arm_q;
  assign timerDone = busy_q & (timer_q == {`SPE_TW{1'b0}});

  assign startArr = csRise & (state_q == ST_WDATA) & byteEnd_q &
                    (mask_q != 32'h0000_0000) & ~prot(bp_q, wrAddr_q);
  assign startSr  = csRise & (state_q == ST_SRWR) & byteEnd_q & ~hwProt;

  assign statusByte = busy_q ? `SPE_SR_BUSYVAL :
                      {arm_q, 3'h0, bp_q, wel_q, busy_q};

  assign txLoad = sckFall & (bitCnt_q == 3'h0) &
                  ((state_q == ST_STAT) || (state_q == ST_RDATA));
  assign txByte = (state_q == ST_STAT) ? statusByte :
                  (fifoOutValid ? fifoOutData : `SPE_IDLE_BYTE);
  assign fillPush = (state_q == ST_RDATA) & ~csS;
  assign fullAddr = {addrHi_q, rxByte};

  // Read data is prefetched so a byte is always ready when its first bit
  // must appear; the FIFO stalls the prefetch once it is full.
  spe_fifo #(
    .WIDTH (8),
    .DEPTH (8),
    .PW    (3)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .flush    (csRise | csFall),
    .inValid  (fillPush),
    .inReady  (fifoInReady),
    .inData   (mem_q[rdAddr_q]),
    .outValid (fifoOutValid),
    .outReady (txLoad & (state_q == ST_RDATA)),
    .outData  (fifoOutData)
  );

  // Array and page buffer hold data only, so they carry no reset.
  always @(posedge clk) begin
    if (byteDone && state_q == ST_WDATA) begin
      page_q[wrAddr_q[`SPE_PW-1:0]] <= rxByte;
    end
    if (timerDone && pendArr_q) begin
      for (i = 0; i < `SPE_PAGE_BYTES; i = i + 1) begin
        if (mask_q[i]) begin
          mem_q[{wrAddr_q[`SPE_AW-1:`SPE_PW], i[`SPE_PW-1:0]}] <= page_q[i];
        end
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      // Matches the synchroniser's reset level so no false rise follows reset;
      // the fall that may follow is masked while the part is deselected.
      sckPrev_q <= 1'b1;
      csPrev_q  <= 1'b1;
    end else begin
      sckPrev_q <= sckS;
      csPrev_q  <= csS;
    end
  end

  // Bit counter and receive shifter.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bitCnt_q  <= 3'h0;
      rx_q      <= 8'h00;
      byteEnd_q <= 1'b0;
    end else if (csFall) begin
      bitCnt_q  <= 3'h0;
      byteEnd_q <= 1'b0;
    end else if (sckRise) begin
      bitCnt_q  <= bitCnt_q + 3'h1;
      rx_q      <= rxByte;
      byteEnd_q <= byteDone;
    end
  end

  // Command state machine and latch.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= ST_IGN;
      rdMode_q   <= 1'b0;
      addrByte_q <= 1'b0;
      addrHi_q   <= 8'h00;
      wel_q      <= 1'b0;
    end else begin
      if (timerDone) begin
        wel_q <= 1'b0;
      end
      if (csFall) begin
        state_q    <= ST_OPC;
        addrByte_q <= 1'b0;
      end else if (csRise) begin
        state_q <= ST_IGN;
      end else if (byteDone) begin
        case (state_q)
          ST_OPC: begin
            if (rxByte[7:4] != `SPE_OP_HI) begin
              state_q <= ST_IGN;
            end else if (busy_q) begin
              state_q <= (rxByte[2:0] == `SPE_OP_STATE_RD) ? ST_STAT : ST_IGN;
            end else begin
              case (rxByte[2:0])
                `SPE_OP_LATCH_SET: begin
                  wel_q   <= 1'b1;
                  state_q <= ST_IGN;
                end
                `SPE_OP_LATCH_CLR: begin
                  wel_q   <= 1'b0;
                  state_q <= ST_IGN;
                end
                `SPE_OP_STATE_RD: begin
                  state_q <= ST_STAT;
                end
                `SPE_OP_STATE_WR: begin
                  state_q <= wel_q ? ST_SRWR : ST_IGN;
                end
                `SPE_OP_ARR_RD: begin
                  rdMode_q <= 1'b1;
                  state_q  <= ST_ADDR;
                end
                `SPE_OP_ARR_WR: begin
                  rdMode_q <= 1'b0;
                  state_q  <= wel_q ? ST_ADDR : ST_IGN;
                end
                default: begin
                  state_q <= ST_IGN;
                end
              endcase
            end
          end
          ST_ADDR: begin
            addrHi_q   <= rxByte;
            addrByte_q <= 1'b1;
            if (addrByte_q) begin
              state_q <= rdMode_q ? ST_RDATA : ST_WDATA;
            end
          end
          default: begin
            state_q <= state_q;
          end
        endcase
      end
    end
  end

  // Addresses and the page mask.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdAddr_q <= {`SPE_AW{1'b0}};
      wrAddr_q <= {`SPE_AW{1'b0}};
      mask_q   <= 32'h0000_0000;
      srPend_q <= `SPE_NV_RESET;
    end else begin
      if (csFall && !busy_q) begin
        mask_q <= 32'h0000_0000;
      end
      if (byteDone && state_q == ST_ADDR && addrByte_q) begin
        rdAddr_q <= fullAddr[`SPE_AW-1:0];
        wrAddr_q <= fullAddr[`SPE_AW-1:0];
      end else if (fillPush && fifoInReady) begin
        rdAddr_q <= rdAddr_q + `SPE_ADDR_ONE;
      end
      if (byteDone && state_q == ST_WDATA) begin
        wrAddr_q[`SPE_PW-1:0] <= wrAddr_q[`SPE_PW-1:0] + `SPE_PAGE_ONE;
        mask_q[wrAddr_q[`SPE_PW-1:0]] <= 1'b1;
      end
      if (byteDone && state_q == ST_SRWR) begin
        srPend_q <= {rxByte[`SPE_SR_ARM], rxByte[`SPE_SR_BPH],
                     rxByte[`SPE_SR_BPL]};
      end
    end
  end

  // Self-timed write cycle and nonvolatile protection bits.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_q    <= 1'b0;
      timer_q   <= {`SPE_TW{1'b0}};
      pendArr_q <= 1'b0;
      pendSr_q  <= 1'b0;
      arm_q     <= 1'b0;
      bp_q      <= 2'h0;
    end else if (busy_q) begin
      if (timerDone) begin
        busy_q    <= 1'b0;
        pendArr_q <= 1'b0;
        pendSr_q  <= 1'b0;
        if (pendSr_q) begin
          arm_q <= srPend_q[2];
          bp_q  <= srPend_q[1:0];
        end
      end else begin
        timer_q <= timer_q - {{(`SPE_TW-1){1'b0}}, 1'b1};
      end
    end else if (startArr || startSr) begin
      busy_q    <= 1'b1;
      timer_q   <= WRITE_CYCLES - {{(`SPE_TW-1){1'b0}}, 1'b1};
      pendArr_q <= startArr;
      pendSr_q  <= startSr;
    end
  end

  // Output shifter: a new byte is presented on the falling edge that
  // follows the last rising edge of the previous byte.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_q    <= 8'h00;
      so_q    <= 1'b0;
      soAct_q <= 1'b0;
    end else if (csS) begin
      soAct_q <= 1'b0;
    end else if (sckFall && (state_q == ST_STAT || state_q == ST_RDATA)) begin
      if (txLoad) begin
        so_q    <= txByte[7];
        tx_q    <= {txByte[6:0], 1'b0};
        soAct_q <= 1'b1;
      end else begin
        so_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign soOe  = soAct_q & ~csS & holdS;
  assign soOut = so_q;
  assign busy  = busy_q;
endmodule // spe_eeprom

// ---- verification/spe_eeprom_chk.sv ----
// Concurrent checks on the pins of the serial EEPROM command block.
// Assumes two sync flops on every pin and SCK low for at least 4 clocks.
`timescale 1ns/1ps
module spe_eeprom_chk #(
  parameter [15:0] WRITE_CYCLES = 16'hC350
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic csPinN,
  input wire logic sckPin,
  input wire logic siPin,
  input wire logic holdPinN,
  input wire logic wpPinN,
  input wire logic soOut,
  input wire logic soOe,
  input wire logic busy
);
  logic [15:0] busyCnt_q;
  logic [15:0] busyCnt_d;

  assign busyCnt_d = busy ? busyCnt_q + 16'h0001 : 16'h0000;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busyCnt_q <= 16'h0000;
    end else begin
      busyCnt_q <= busyCnt_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence csHigh;
    csPinN [*4];
  endsequence
  sequence holdLow;
    !holdPinN [*4];
  endsequence
  sequence busyEnd;
    busy ##1 !busy;
  endsequence

  csIdle_a: assert property (csHigh |-> !soOe)
    else $error("SO driven while deselected");
  holdIdle_a: assert property (holdLow |-> !soOe)
    else $error("SO driven while paused");
  oeSelect_a: assert property (soOe |-> !$past(csPinN, 2))
    else $error("SO enabled without select");
  oeHold_a: assert property (soOe |-> $past(holdPinN, 2))
    else $error("SO enabled during pause");
  soEdge_a: assert property (soOe && $changed(soOut) |-> !$past(sckPin, 2))
    else $error("SO changed outside SCK low");
  busyStart_a: assert property ($rose(busy) |-> $past(csPinN, 2))
    else $error("write cycle began while selected");
  busyLen_a: assert property (busyEnd |-> busyCnt_q == WRITE_CYCLES)
    else $error("write cycle length wrong");
  busyCap_a: assert property (busyCnt_q <= WRITE_CYCLES)
    else $error("write cycle overran");
endmodule // spe_eeprom_chk

bind spe_eeprom spe_eeprom_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_spe_eeprom_chk (
  .clk(clk), .rst(rst), .csPinN(csPinN), .sckPin(sckPin), .siPin(siPin),
  .holdPinN(holdPinN), .wpPinN(wpPinN), .soOut(soOut), .soOe(soOe), .busy(busy));

// ---- verification/spe_master.sv ----
// SPI mode 0 master model that frames commands for the EEPROM block.
// Assumes a 100 ns clk; SCK half period is 4 clocks and idles low.
`timescale 1ns/1ps
module spe_master (
  input  wire logic clk,
  output logic      csPinN,
  output logic      sckPin,
  output logic      siPin,
  input  wire logic soOut,
  input  wire logic soOe
);
  logic lastSo = 1'b0;
  logic soLine;

  // A released SO line shows the inverse of its last level, so stale data never matches.
  assign soLine = soOe ? soOut : ~lastSo;

  always @(posedge clk) begin
    if (soOe === 1'b1) begin
      lastSo <= soOut;
    end
  end

  initial begin
    csPinN = 1'b1;
    sckPin = 1'b0;
    siPin  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic sel();
    csPinN = 1'b0;
    tick(4);
  endtask

  task automatic desel();
    tick(2);
    csPinN = 1'b1;
    tick(4);
  endtask

  task automatic bit1(input logic b, output logic r);
    siPin = b;
    tick(4);
    r = soLine;
    sckPin = 1'b1;
    tick(4);
    sckPin = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      bit1(tx[i], rx[i]);
    end
  endtask
endmodule // spe_master

// ---- verification/tb_spe_eeprom.sv ----
// Self-checking bench for the serial EEPROM command block.
// Assumes the master model paces SCK at 800 ns and a shortened write cycle.
`timescale 1ns/1ps
module tb_spe_eeprom;
  localparam logic [15:0] WC = 16'h0258;
  logic       clk;
  logic       rst;
  logic       holdPinN;
  logic       wpPinN;
  int         oeCount = 0;
  int         oeBase;
  logic [7:0] r;
  logic [7:0] dat [0:3];
  int         n_mismatch;
  int         compares;
  int         cycles = 0;
  wire        csPinN;
  wire        sckPin;
  wire        siPin;
  wire        soOut;
  wire        soOe;
  wire        busy;

  spe_eeprom #(.WRITE_CYCLES(WC)) u_spe_eeprom (.clk(clk), .rst(rst), .csPinN(csPinN),
    .sckPin(sckPin), .siPin(siPin), .holdPinN(holdPinN), .wpPinN(wpPinN),
    .soOut(soOut), .soOe(soOe), .busy(busy));
  spe_master u_spe_master (.clk(clk), .csPinN(csPinN), .sckPin(sckPin), .siPin(siPin),
    .soOut(soOut), .soOe(soOe));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The ceiling is about twice the expected run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (soOe === 1'b1) begin
      oeCount <= oeCount + 1;
    end
    if (cycles == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xb(input logic [7:0] tx);
    u_spe_master.xfer(tx, r);
  endtask

  task automatic cmd1(input logic [7:0] op);
    u_spe_master.sel();
    xb(op);
    u_spe_master.desel();
  endtask

  task automatic sr(input logic [7:0] op, input logic [7:0] exp);
    cmd1(op);
    u_spe_master.sel();
    xb(op);
    xb(8'hA5);
    u_spe_master.desel();
    chk(r, exp);
  endtask

  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    u_spe_master.sel();
    xb(op);
    xb(a[15:8]);
    xb(a[7:0]);
  endtask

  task automatic wr(input logic [7:0] op, input logic [15:0] a, input int n);
    hdr(op, a);
    for (int i = 0; i < n; i++) begin
      xb(dat[i]);
    end
    u_spe_master.desel();
  endtask

  task automatic rd(input logic [7:0] op, input logic [15:0] a, input int n);
    hdr(op, a);
    for (int i = 0; i < n; i++) begin
      xb(8'hFF);
      chk(r, dat[i]);
    end
    u_spe_master.desel();
  endtask

  task automatic wsr(input logic [7:0] v);
    cmd1(8'h06);
    u_spe_master.sel();
    xb(8'h01);
    xb(v);
    u_spe_master.desel();
  endtask

  // Sends a command that must leave SO released for the whole frame.
  task automatic mute(input logic [7:0] op);
    oeBase = oeCount;
    hdr(op, 16'h0000);
    xb(8'hFF);
    u_spe_master.desel();
    chk({7'h00, oeCount != oeBase}, 8'h00);
  endtask

  task automatic bz(input logic eb);
    chk({7'h00, busy}, {7'h00, eb});
  endtask

  task automatic idle();
    for (int i = 0; i < 1000 && busy === 1'b1; i++) begin
      @(negedge clk);
    end
  endtask

  initial begin
    rst = 1'b1;
    holdPinN = 1'b1;
    wpPinN = 1'b1;
    n_mismatch = 0;
    compares = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    sr(8'h05, 8'h00);
    cmd1(8'h0E);
    sr(8'h0D, 8'h02);
    cmd1(8'h0C);
    sr(8'h05, 8'h00);
    cmd1(8'h06);
    dat = '{8'h11, 8'h22, 8'h33, 8'h00};
    wr(8'h02, 16'hF01E, 3);
    bz(1'b1);
    sr(8'h05, 8'hFF);
    mute(8'h03);
    idle();
    sr(8'h05, 8'h00);
    cmd1(8'h06);
    dat[0] = 8'h44;
    wr(8'h0A, 16'h0FFF, 1);
    bz(1'b1);
    idle();
    dat = '{8'h44, 8'h33, 8'h00, 8'h00};
    rd(8'h0B, 16'h0FFF, 2);
    dat = '{8'h11, 8'h22, 8'h00, 8'h00};
    rd(8'h03, 16'h001E, 2);
    mute(8'h83);
    mute(8'h07);
    cmd1(8'h06);
    cmd1(8'h04);
    wr(8'h02, 16'h0100, 1);
    bz(1'b0);
    cmd1(8'h06);
    hdr(8'h02, 16'h0100);
    xb(8'h5A);
    u_spe_master.bit1(1'b1, r[0]);
    u_spe_master.desel();
    bz(1'b0);
    for (int l = 1; l < 4; l++) begin
      wsr({4'h0, l[1:0], 2'b00});
      idle();
      sr(8'h05, {4'h0, l[1:0], 2'b00});
      cmd1(8'h06);
      wr(8'h02, (l == 1) ? 16'h0C00 : (l == 2) ? 16'h0800 : 16'h0000, 1);
      bz(1'b0);
      if (l < 3) begin
        wr(8'h02, (l == 1) ? 16'h0BFF : 16'h07FF, 1);
        bz(1'b1);
        idle();
      end
    end
    wsr(8'hF0);
    idle();
    sr(8'h05, 8'h80);
    wpPinN = 1'b0;
    wsr(8'h00);
    bz(1'b0);
    sr(8'h05, 8'h82);
    wpPinN = 1'b1;
    wsr(8'h00);
    bz(1'b1);
    idle();
    // An array read, since a status read repeats one byte and would hide a
    // pause that failed to freeze the shifter.
    hdr(8'h03, 16'h0FFF);
    u_spe_master.tick(4);
    holdPinN = 1'b0;
    xb(8'hFF);
    chk({7'h00, soOe}, 8'h00);
    u_spe_master.tick(4);
    holdPinN = 1'b1;
    xb(8'hFF);
    chk(r, 8'h44);
    xb(8'hFF);
    u_spe_master.desel();
    chk(r, 8'h33);
    results();
  end
endmodule // tb_spe_eeprom
